// [hdl/aoxu_unit.sv]
// Accumulator OR/XOR datapath with stack and status flags.
`timescale 1ns/10ps
`default_nettype none
module aoxu_unit import aoxu_pkg::*; (
  input wire logic clk_sys_in, // 250 MHz instruction clock
  input wire logic rst_in, // Async reset, active high
  input wire logic cmd_valid_in, // One-cycle instruction strobe
  input wire aoxu_cmd_t cmd_in, // Instruction and operand
  output logic [AOXU_ACC_W-1:0] acc_out, // Accumulator
  output logic [AOXU_ACC_W-1:0] stack_top_out, // Stack first level
  output logic zero_result_flag_out, // Result zero
  output logic sign_or_load_zero_flag_out, // Sign or loaded-zero
  output logic done_out, // Instruction executed pulse
  output logic range_error_out // Bit-range operand refused pulse
);
  aoxu_state_t st, next_st;

  // Mask of the low count bits; count 32 gives all ones
  function automatic logic [AOXU_ACC_W-1:0] low_mask(input logic [AOXU_CNT_W-1:0] n);
    logic [AOXU_ACC_W:0] m;
    m = ({{AOXU_ACC_W{1'b0}}, 1'b1} << n) - {{AOXU_ACC_W{1'b0}}, 1'b1};
    return m[AOXU_ACC_W-1:0];
  endfunction

  // Last bit touched by the run must stay within the area's address span
  function automatic logic range_ok(input aoxu_cmd_t c);
    logic [AOXU_ADDR_W:0] last;
    logic [AOXU_ADDR_W-1:0] lim;
    last = {1'b0, c.bit_start} + {{(AOXU_ADDR_W+1-AOXU_CNT_W){1'b0}}, c.bit_count}
      - {{AOXU_ADDR_W{1'b0}}, 1'b1};
    if (c.area == AOXU_AREA_IO) begin
      lim = AOXU_IO_MAX;
    end else if (c.area == AOXU_AREA_RELAY) begin
      lim = AOXU_RELAY_MAX;
    end else if (c.area == AOXU_AREA_TIMER) begin
      lim = AOXU_TIMER_MAX;
    end else begin
      lim = AOXU_IO_MAX;
    end
    return (c.bit_count >= AOXU_CNT_MIN) && (c.bit_count <= AOXU_CNT_MAX)
      && (last <= {1'b0, lim});
  endfunction

  always_comb begin
    logic [AOXU_ACC_W-1:0] res;
    logic wr;
    res = st.acc;
    wr = 1'b0;
    next_st = st;
    next_st.done = 1'b0;
    next_st.range_error = 1'b0;
    if (cmd_valid_in) begin
      case (cmd_in.op)
        AOXU_OP_OR: begin
          // Upper half left alone by the 16-bit form
          res = {st.acc[31:16], st.acc[15:0] | cmd_in.operand[15:0]};
          wr = 1'b1;
        end
        AOXU_OP_XOR: begin
          res = {st.acc[31:16], st.acc[15:0] ^ cmd_in.operand[15:0]};
          wr = 1'b1;
        end
        AOXU_OP_OR_DBL: begin
          res = st.acc | cmd_in.operand;
          wr = 1'b1;
        end
        AOXU_OP_XOR_DBL: begin
          res = st.acc ^ cmd_in.operand;
          wr = 1'b1;
        end
        AOXU_OP_OR_RANGE: begin
          // Operand carries the gathered bits, lowest address in bit 0
          if (range_ok(cmd_in)) begin
            res = st.acc | (cmd_in.operand & low_mask(cmd_in.bit_count));
            wr = 1'b1;
          end else begin
            next_st.range_error = 1'b1;
          end
        end
        AOXU_OP_ORS: begin
          res = st.acc | st.stack[0];
          wr = 1'b1;
          for (int i = 0; i < AOXU_STK_DEPTH - 1; i++) begin
            next_st.stack[i] = st.stack[i+1];
          end
          next_st.stack[AOXU_STK_DEPTH-1] = AOXU_ACC_RST;
        end
        AOXU_OP_LOAD: begin
          next_st.acc = cmd_in.operand;
          next_st.sign_or_load_zero_flag = (cmd_in.operand == AOXU_ACC_RST);
          next_st.done = 1'b1;
        end
        AOXU_OP_PUSH: begin
          // Load that pushes the old accumulator down one level
          for (int i = AOXU_STK_DEPTH - 1; i > 0; i--) begin
            next_st.stack[i] = st.stack[i-1];
          end
          next_st.stack[0] = st.acc;
          next_st.acc = cmd_in.operand;
          next_st.sign_or_load_zero_flag = (cmd_in.operand == AOXU_ACC_RST);
          next_st.done = 1'b1;
        end
        default: begin
          wr = 1'b0;
        end
      endcase
      if (wr) begin
        next_st.acc = res;
        next_st.done = 1'b1;
        next_st.zero_result_flag = (res == AOXU_ACC_RST);
        if (cmd_in.op == AOXU_OP_OR_DBL || cmd_in.op == AOXU_OP_XOR_DBL) begin
          next_st.sign_or_load_zero_flag = res[AOXU_ACC_W-1];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign acc_out = st.acc;
  assign stack_top_out = st.stack[0];
  assign zero_result_flag_out = st.zero_result_flag;
  assign sign_or_load_zero_flag_out = st.sign_or_load_zero_flag;
  assign done_out = st.done;
  assign range_error_out = st.range_error;

  sequence s_or16;
    cmd_valid_in && cmd_in.op == AOXU_OP_OR;
  endsequence
  sequence s_ors;
    cmd_valid_in && cmd_in.op == AOXU_OP_ORS;
  endsequence
  sequence s_idle;
    !cmd_valid_in;
  endsequence
  sequence s_range_taken;
    cmd_valid_in && cmd_in.op == AOXU_OP_OR_RANGE && range_ok(cmd_in);
  endsequence
  sequence s_range_refused;
    cmd_valid_in && cmd_in.op == AOXU_OP_OR_RANGE && !range_ok(cmd_in);
  endsequence

  chk_or16_result: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_or16 |=> acc_out[15:0] == ($past(acc_out[15:0]) | $past(cmd_in.operand[15:0])))
    else $error("16-bit OR result wrong");
  chk_upper_kept: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && (cmd_in.op == AOXU_OP_OR || cmd_in.op == AOXU_OP_XOR)
    |=> acc_out[31:16] == $past(acc_out[31:16]))
    else $error("16-bit form changed upper half");
  chk_xor16_result: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && cmd_in.op == AOXU_OP_XOR
    |=> acc_out[15:0] == ($past(acc_out[15:0]) ^ $past(cmd_in.operand[15:0])))
    else $error("16-bit XOR result wrong");
  chk_or32_result: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && cmd_in.op == AOXU_OP_OR_DBL
    |=> acc_out == ($past(acc_out) | $past(cmd_in.operand)))
    else $error("double OR result wrong");
  chk_xor32_result: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && cmd_in.op == AOXU_OP_XOR_DBL
    |=> acc_out == ($past(acc_out) ^ $past(cmd_in.operand)))
    else $error("double XOR result wrong");
  chk_zero_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    done_out && !$past(cmd_in.op == AOXU_OP_LOAD || cmd_in.op == AOXU_OP_PUSH)
    |-> zero_result_flag_out == (acc_out == AOXU_ACC_RST))
    else $error("zero flag disagrees with result");
  chk_sign_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && (cmd_in.op == AOXU_OP_OR_DBL || cmd_in.op == AOXU_OP_XOR_DBL)
    |=> sign_or_load_zero_flag_out == acc_out[31])
    else $error("sign flag disagrees with bit 31");
  chk_load_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && cmd_in.op == AOXU_OP_LOAD
    |=> sign_or_load_zero_flag_out == (acc_out == AOXU_ACC_RST))
    else $error("load-zero flag wrong");
  chk_flag_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_idle ##1 s_idle |=> $stable(zero_result_flag_out) && $stable(sign_or_load_zero_flag_out))
    else $error("flag changed without instruction");
  chk_range_mask: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && cmd_in.op == AOXU_OP_OR_RANGE && cmd_in.bit_count == AOXU_CNT_MIN
    && range_ok(cmd_in) |=> acc_out[31:1] == $past(acc_out[31:1]))
    else $error("bit-range touched bits above count");
  chk_range_refuse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && cmd_in.op == AOXU_OP_OR_RANGE && cmd_in.bit_count > AOXU_CNT_MAX
    |=> range_error_out && !done_out && $stable(acc_out))
    else $error("bad bit count not refused");
  chk_stack_or: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_ors |=> acc_out == ($past(acc_out) | $past(stack_top_out)))
    else $error("stack OR result wrong");
  chk_stack_pop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_ors |=> stack_top_out == $past(st.stack[1]))
    else $error("stack did not shift up");
  chk_range_full: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && cmd_in.op == AOXU_OP_OR_RANGE && cmd_in.bit_count == AOXU_CNT_MAX
    && range_ok(cmd_in) |=> acc_out == ($past(acc_out) | $past(cmd_in.operand)))
    else $error("full bit-range OR result wrong");
  chk_range_span: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_range_refused |=> range_error_out && !done_out && $stable(acc_out)
    && $stable(zero_result_flag_out))
    else $error("out-of-span bit range not refused");
  chk_range_taken: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_range_taken |=> done_out && !range_error_out)
    else $error("legal bit range refused");
  chk_load_keeps_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && (cmd_in.op == AOXU_OP_LOAD || cmd_in.op == AOXU_OP_PUSH)
    |=> $stable(zero_result_flag_out))
    else $error("load changed the zero result flag");
  chk_union_keeps_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && (cmd_in.op == AOXU_OP_OR || cmd_in.op == AOXU_OP_XOR
    || cmd_in.op == AOXU_OP_OR_RANGE || cmd_in.op == AOXU_OP_ORS)
    |=> $stable(sign_or_load_zero_flag_out))
    else $error("union changed the load-zero flag");
  chk_stack_fill: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_ors |=> st.stack[AOXU_STK_DEPTH-1] == AOXU_ACC_RST)
    else $error("popped stack bottom not cleared");
endmodule
`default_nettype wire

// [hdl/aoxu_pkg.sv]
// Package for the accumulator OR/XOR unit: constants, types and behaviour notes.
// Notes on behaviour
// - Sixteen-bit OR low accumulator with memory word
// - Zero flag follows every union result
// - Double forms: sign flag is result bit 31
// - Other forms: flag marks zero load value
// - Flags hold until next writing instruction
// - Double OR with word pair or constant
// - Bit-range OR, 1 to 32 low bits
// - Bit range: start address plus bit count
// - Stack union ORs accumulator with stack top
// - Stack union pops; entries shift up one
// - Sixteen-bit XOR low accumulator with word
// - Double XOR with word pair or constant
package aoxu_pkg;
  localparam int AOXU_ACC_W = 32;
  localparam int AOXU_STK_DEPTH = 8;
  localparam int AOXU_STK_IDX_W = 3;
  localparam int AOXU_CNT_W = 6;
  localparam int AOXU_ADDR_W = 11;
  localparam logic [AOXU_CNT_W-1:0] AOXU_CNT_MIN = 6'h01;
  localparam logic [AOXU_CNT_W-1:0] AOXU_CNT_MAX = 6'h20;
  localparam logic [AOXU_ADDR_W-1:0] AOXU_IO_MAX = 11'h1FF;
  localparam logic [AOXU_ADDR_W-1:0] AOXU_RELAY_MAX = 11'h3FF;
  localparam logic [AOXU_ADDR_W-1:0] AOXU_TIMER_MAX = 11'h0FF;
  localparam logic [AOXU_ACC_W-1:0] AOXU_ACC_RST = 32'h0000_0000;
  localparam logic [AOXU_ACC_W-1:0] AOXU_K_MAX = 32'h0FFF_FFFF;

  typedef enum logic [3:0] {
    AOXU_OP_NONE, AOXU_OP_OR, AOXU_OP_OR_DBL, AOXU_OP_OR_RANGE, AOXU_OP_ORS,
    AOXU_OP_XOR, AOXU_OP_XOR_DBL, AOXU_OP_LOAD, AOXU_OP_PUSH
  } aoxu_op_t;

  typedef enum logic [1:0] {
    AOXU_AREA_IO, AOXU_AREA_RELAY, AOXU_AREA_TIMER, AOXU_AREA_OTHER
  } aoxu_area_t;

  typedef struct packed {
    aoxu_op_t op;
    logic [AOXU_ACC_W-1:0] operand;
    logic [AOXU_CNT_W-1:0] bit_count;
    logic [AOXU_ADDR_W-1:0] bit_start;
    aoxu_area_t area;
  } aoxu_cmd_t;

  typedef struct packed {
    logic [AOXU_ACC_W-1:0] acc;
    logic [AOXU_STK_DEPTH-1:0][AOXU_ACC_W-1:0] stack;
    logic zero_result_flag;
    logic sign_or_load_zero_flag;
    logic done;
    logic range_error;
  } aoxu_state_t;
endpackage

// [tb/test_accumulator_or_xor_unit.sv]
// Self-checking bench for the accumulator OR/XOR unit.
`timescale 1ns/10ps
`default_nettype none
`define CMP(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_accumulator_or_xor_unit import aoxu_pkg::*;;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  aoxu_cmd_t cmd_in = '0;
  logic [AOXU_ACC_W-1:0] acc_out;
  logic [AOXU_ACC_W-1:0] stack_top_out;
  logic zero_result_flag_out;
  logic sign_or_load_zero_flag_out;
  logic done_out;
  logic range_error_out;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  aoxu_unit aoxu_unit_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .acc_out(acc_out),
    .stack_top_out(stack_top_out), .zero_result_flag_out(zero_result_flag_out),
    .sign_or_load_zero_flag_out(sign_or_load_zero_flag_out), .done_out(done_out),
    .range_error_out(range_error_out));
  always #2 clk_sys_in = ~clk_sys_in;
  // The whole run needs well under 100 cycles; this only cuts a hang short
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Counts: checked %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Valid stays high between calls, so consecutive calls are back to back
  task automatic run(input aoxu_op_t opc, input logic [31:0] v, input logic [5:0] n,
      input logic [10:0] a, input aoxu_area_t ar, input logic ok);
    cmd_valid_in = 1'b1;
    cmd_in = '{op: opc, operand: v, bit_count: n, bit_start: a, area: ar};
    @(posedge clk_sys_in);
    #1;
    `CMP("done", ok, done_out)
    `CMP("refused", ~ok, range_error_out)
  endtask
  task automatic op(input aoxu_op_t o, input logic [31:0] v);
    run(o, v, 6'h00, 11'h000, AOXU_AREA_IO, 1'b1);
  endtask
  task automatic see(input logic [31:0] a, input logic z, input logic s);
    `CMP("acc", a, acc_out)
    `CMP("zero flag", z, zero_result_flag_out)
    `CMP("sign flag", s, sign_or_load_zero_flag_out)
  endtask
  task automatic end_test(input string nm);
    cmd_valid_in = 1'b0;
    @(posedge clk_sys_in);
    #1;
    $display("%s finished", nm);
  endtask
  task automatic t_single();
    op(AOXU_OP_LOAD, 32'hA5A5_0000);
    see(32'hA5A5_0000, 1'b0, 1'b0);
    op(AOXU_OP_OR, 32'hFFFF_0F0F);
    see(32'hA5A5_0F0F, 1'b0, 1'b0);
    op(AOXU_OP_LOAD, 32'h0000_0000);
    see(32'h0000_0000, 1'b0, 1'b1);
    op(AOXU_OP_OR, 32'hFFFF_0000);
    see(32'h0000_0000, 1'b1, 1'b1);
    op(AOXU_OP_LOAD, 32'h1234_00FF);
    see(32'h1234_00FF, 1'b1, 1'b0);
    op(AOXU_OP_XOR, 32'hFFFF_00FF);
    see(32'h1234_0000, 1'b0, 1'b0);
    end_test("single");
  endtask
  task automatic t_double();
    op(AOXU_OP_LOAD, 32'h0000_0000);
    op(AOXU_OP_OR_DBL, 32'h8000_0001);
    see(32'h8000_0001, 1'b0, 1'b1);
    op(AOXU_OP_XOR_DBL, 32'h8000_0001);
    see(32'h0000_0000, 1'b1, 1'b0);
    op(AOXU_OP_OR_DBL, AOXU_K_MAX);
    see(32'h0FFF_FFFF, 1'b0, 1'b0);
    op(AOXU_OP_XOR_DBL, 32'hFFFF_FFFF);
    see(32'hF000_0000, 1'b0, 1'b1);
    end_test("double");
  endtask
  task automatic t_range();
    logic [5:0] n [5] = '{6'h00, 6'h21, 6'h20, 6'h02, 6'h02};
    logic [10:0] a [5] = '{11'h000, 11'h000, 11'h1E1, 11'h0FF, 11'h3FF};
    aoxu_area_t ar [5] = '{AOXU_AREA_IO, AOXU_AREA_IO, AOXU_AREA_IO, AOXU_AREA_TIMER,
      AOXU_AREA_RELAY};
    op(AOXU_OP_LOAD, 32'h0000_0000);
    run(AOXU_OP_OR_RANGE, 32'hFFFF_FFFF, 6'h04, 11'h000, AOXU_AREA_IO, 1'b1);
    see(32'h0000_000F, 1'b0, 1'b1);
    run(AOXU_OP_OR_RANGE, 32'hFFFF_FFF0, 6'h05, 11'h3FB, AOXU_AREA_RELAY, 1'b1);
    see(32'h0000_001F, 1'b0, 1'b1);
    run(AOXU_OP_OR_RANGE, 32'hFFFF_FFFE, 6'h01, 11'h0FF, AOXU_AREA_TIMER, 1'b1);
    see(32'h0000_001F, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      run(AOXU_OP_OR_RANGE, 32'hFFFF_FFFF, n[i], a[i], ar[i], 1'b0);
      see(32'h0000_001F, 1'b0, 1'b1);
    end
    run(AOXU_OP_OR_RANGE, 32'hFFFF_FFFF, 6'h20, 11'h1E0, AOXU_AREA_OTHER, 1'b1);
    see(32'hFFFF_FFFF, 1'b0, 1'b1);
    end_test("range");
  endtask
  // Each push loads the same value it pushes, so either push reading agrees
  task automatic t_stack();
    op(AOXU_OP_LOAD, 32'h0000_00A0);
    op(AOXU_OP_PUSH, 32'h0000_00A0);
    `CMP("stack", 32'h0000_00A0, stack_top_out)
    op(AOXU_OP_LOAD, 32'h0000_0B00);
    op(AOXU_OP_PUSH, 32'h0000_0B00);
    op(AOXU_OP_LOAD, 32'h8000_000C);
    op(AOXU_OP_ORS, 32'h0000_0000);
    see(32'h8000_0B0C, 1'b0, 1'b0);
    `CMP("stack", 32'h0000_00A0, stack_top_out)
    op(AOXU_OP_ORS, 32'h0000_0000);
    see(32'h8000_0BAC, 1'b0, 1'b0);
    `CMP("stack", 32'h0000_0000, stack_top_out)
    end_test("stack");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    see(AOXU_ACC_RST, 1'b0, 1'b0);
    t_single();
    t_double();
    t_range();
    t_stack();
    complete_run();
  end
endmodule
`default_nettype wire
